// file: verilog/smf_top.sv
// spi master with transmit and receive fifos behind an apb slave
//
// Local design decision: the APB interface to the registers.
`include "smf_cfg.svh"

module smf_top #(
    parameter int FIFO_DEPTH = `SMF_FIFO_DEPTH,
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic serial_clock_line,
    output logic serial_out_line,
    input wire logic serial_in_line,
    output logic [1:0] slave_select_n,
    output logic irq_n
);

    if (ADDR_W < 10) begin : g_bad_addr_w
        $error("smf_top: ADDR_W must reach the register window");
    end

    // ****************************************
    // address decode
    // ****************************************

    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        hits = (addr == ADDR_W'({idx, 2'b00}));
    endfunction : hits

    wire sel_data = hits(paddr, `SMF_IDX_DATA);
    wire sel_ctrl = hits(paddr, `SMF_IDX_CTRL);
    wire sel_stat = hits(paddr, `SMF_IDX_STAT);
    wire sel_div = hits(paddr, `SMF_IDX_DIV);
    wire sel_any = sel_data || sel_ctrl || sel_stat || sel_div;

    wire apb_setup = psel && !penable;
    wire apb_done = psel && penable && pready;
    wire wr_done = apb_done && pwrite && sel_any;
    wire rd_done = apb_done && !pwrite && sel_any;

    // ****************************************
    // registers
    // ****************************************

    logic [7:0] ctrl;
    logic [7:0] divisor;
    logic flag_ovf;
    logic flag_emt;

    wire [7:0] wbyte = pwdata[7:0];
    wire ctrl_wr = wr_done && sel_ctrl;
    wire ss_active = ctrl[`SMF_CTRL_SS_ACT];
    wire cpol = ctrl[`SMF_CTRL_CPOL];
    wire cpha = ctrl[`SMF_CTRL_CPHA];
    wire ss_drop = ctrl_wr && ss_active && !wbyte[`SMF_CTRL_SS_ACT];

    // bit 7 of control always reads zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl <= `SMF_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= {1'b0, wbyte[6:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            divisor <= `SMF_DIV_RESET;
        end else if (wr_done && sel_div) begin
            divisor <= wbyte;
        end
    end

    // ****************************************
    // fifos
    // ****************************************

    wire tx_push = wr_done && sel_data;
    wire rx_pop = rd_done && sel_data;
    logic tx_pop;
    logic rx_push;
    logic [7:0] rx_byte;
    logic [7:0] tx_head;
    logic [7:0] rx_head;
    logic tx_empty;
    logic tx_full;
    logic rx_empty;
    logic rx_full;

    // write when full overwrites rather than refuses
    smf_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .flush(ss_drop),
        .push(tx_push),
        .push_data(wbyte),
        .pop(tx_pop),
        .pop_data(tx_head),
        .empty(tx_empty),
        .full(tx_full)
    );

    smf_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .flush(ss_drop),
        .push(rx_push),
        .push_data(rx_byte),
        .pop(rx_pop),
        .pop_data(rx_head),
        .empty(rx_empty),
        .full(rx_full)
    );

    // ****************************************
    // serial input synchroniser
    // ****************************************

    logic sin_meta;
    logic sin_sync;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sin_meta <= 1'b0;
            sin_sync <= 1'b0;
        end else begin
            sin_meta <= serial_in_line;
            sin_sync <= sin_meta;
        end
    end

    // ****************************************
    // serial engine
    // ****************************************

    smf_pkg::smf_state_t state;
    smf_pkg::smf_state_t next_state;
    logic [7:0] half_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;

    wire half_end = (half_cnt == 8'h00);
    wire start = (state == smf_pkg::SMF_ST_IDLE) && ss_active && !tx_empty && !ss_drop;
    wire lead_edge = (state == smf_pkg::SMF_ST_LEAD) && half_end;
    wire trail_edge = (state == smf_pkg::SMF_ST_TRAIL) && half_end;
    wire byte_end = trail_edge && (bit_cnt == 3'h0);
    wire sample_now = cpha ? trail_edge : lead_edge;
    wire [7:0] rx_next = {rx_sh[6:0], sin_sync};

    assign tx_pop = start;
    assign rx_push = byte_end;
    assign rx_byte = cpha ? rx_next : rx_sh;

    always_comb begin
        next_state = state;
        unique case (state)
            smf_pkg::SMF_ST_IDLE: begin
                if (start) begin
                    next_state = smf_pkg::SMF_ST_LEAD;
                end
            end
            smf_pkg::SMF_ST_LEAD: begin
                if (half_end) begin
                    next_state = smf_pkg::SMF_ST_TRAIL;
                end
            end
            smf_pkg::SMF_ST_TRAIL: begin
                if (byte_end) begin
                    next_state = smf_pkg::SMF_ST_IDLE;
                end else if (half_end) begin
                    next_state = smf_pkg::SMF_ST_LEAD;
                end
            end
            default: begin
                next_state = smf_pkg::SMF_ST_IDLE;
            end
        endcase
    end

    // clearing slave select aborts any byte in flight
    always_ff @(posedge core_clk) begin
        if (srst || ss_drop) begin
            state <= smf_pkg::SMF_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // half period lasts divisor plus one core cycles
    always_ff @(posedge core_clk) begin
        if (srst || start || half_end) begin
            half_cnt <= divisor;
        end else begin
            half_cnt <= half_cnt - 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || start) begin
            bit_cnt <= 3'h7;
        end else if (trail_edge) begin
            bit_cnt <= bit_cnt - 3'h1;
        end
    end

    // phase 0 shifts on trailing edge, phase 1 on leading edge
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_sh <= 8'h00;
        end else if (start) begin
            tx_sh <= cpha ? tx_head : {tx_head[6:0], 1'b0};
        end else if ((cpha && lead_edge) || (!cpha && trail_edge)) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || start) begin
            rx_sh <= 8'h00;
        end else if (sample_now) begin
            rx_sh <= rx_next;
        end
    end

    // ****************************************
    // pin outputs
    // ****************************************

    always_ff @(posedge core_clk) begin
        if (srst) begin
            serial_out_line <= 1'b0;
        end else if (start && !cpha) begin
            serial_out_line <= tx_head[7];
        end else if (cpha && lead_edge) begin
            serial_out_line <= tx_sh[7];
        end else if (!cpha && trail_edge && !byte_end) begin
            serial_out_line <= tx_sh[7];
        end
    end

    // idle level follows polarity, toggles at each half end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            serial_clock_line <= 1'b0;
        end else if (state == smf_pkg::SMF_ST_IDLE) begin
            serial_clock_line <= cpol;
        end else if (lead_edge) begin
            serial_clock_line <= !cpol;
        end else if (trail_edge) begin
            serial_clock_line <= cpol;
        end
    end

    wire [1:0] next_ss_n = {
        !(ss_active && ctrl[`SMF_CTRL_SS_SEL]),
        !(ss_active && !ctrl[`SMF_CTRL_SS_SEL])
    };

    always_ff @(posedge core_clk) begin
        if (srst) begin
            slave_select_n <= 2'b11;
        end else begin
            slave_select_n <= next_ss_n;
        end
    end

    // ****************************************
    // status flags and interrupt
    // ****************************************

    wire stat_wr = wr_done && sel_stat;
    wire ovf_event = tx_push && tx_full && !tx_pop;
    wire emt_event = byte_end && tx_empty;
    wire engine_idle = (state == smf_pkg::SMF_ST_IDLE) && tx_empty;

    // a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (srst) begin
            flag_ovf <= 1'b0;
            flag_emt <= 1'b0;
        end else begin
            flag_ovf <= ovf_event || (flag_ovf && !(stat_wr && wbyte[`SMF_STAT_OVF]));
            flag_emt <= emt_event || (flag_emt && !(stat_wr && wbyte[`SMF_STAT_EMT]));
        end
    end

    wire irq_req = !ctrl[`SMF_CTRL_MASK]
        && ((flag_ovf && ctrl[`SMF_CTRL_OVF_EN]) || (flag_emt && ctrl[`SMF_CTRL_EMT_EN]));

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !irq_req;
        end
    end

    wire [7:0] stat_val = {
        engine_idle,
        tx_full,
        rx_full,
        rx_empty,
        flag_ovf,
        flag_emt,
        2'b00
    };

    // ****************************************
    // apb answer
    // ****************************************

    wire [7:0] rd_mux = sel_data ? rx_head :
        sel_ctrl ? ctrl :
        sel_stat ? stat_val :
        sel_div ? divisor : 8'h00;

    // one wait-free access phase; data captured at setup
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !sel_any;
            if (apb_setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_mux};
            end
        end
    end

endmodule : smf_top

// file: shared/smf_cfg.svh
// register offsets, field positions, reset values and limits of the spi master block
`ifndef SMF_CFG_SVH
`define SMF_CFG_SVH

// register indices; byte address is four times the index
`define SMF_IDX_DATA 8'hb8
`define SMF_IDX_CTRL 8'hb9
`define SMF_IDX_STAT 8'hba
`define SMF_IDX_DIV 8'hbb

// control register fields
`define SMF_CTRL_CPHA 0
`define SMF_CTRL_CPOL 1
`define SMF_CTRL_EMT_EN 2
`define SMF_CTRL_OVF_EN 3
`define SMF_CTRL_SS_ACT 4
`define SMF_CTRL_SS_SEL 5
`define SMF_CTRL_MASK 6

// status register fields
`define SMF_STAT_EMT 2
`define SMF_STAT_OVF 3
`define SMF_STAT_RX_EMPTY 4
`define SMF_STAT_RX_FULL 5
`define SMF_STAT_TX_FULL 6
`define SMF_STAT_IDLE 7

// reset values
`define SMF_CTRL_RESET 8'h00
`define SMF_DIV_RESET 8'h1f

// fifo depth
`define SMF_FIFO_DEPTH 16

`endif

// file: shared/smf_pkg.sv
// types of the spi master block
package smf_pkg;

    // serial engine states
    typedef enum logic [2:0] {
        SMF_ST_IDLE = 3'b001,
        SMF_ST_LEAD = 3'b010,
        SMF_ST_TRAIL = 3'b100
    } smf_state_t;

endpackage : smf_pkg

// file: verilog/smf_fifo.sv
// byte fifo that overwrites on push when full
module smf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] pop_data,
    output logic empty,
    output logic full
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("smf_fifo: DEPTH must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("smf_fifo: WIDTH must be positive");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;

    wire do_pop = pop && !empty;
    wire do_push = push;

    assign pop_data = mem[rp];
    assign empty = (count == '0);
    assign full = (count == (AW+1)'(DEPTH));

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wp] <= push_data;
        end
    end

    // on a full push without a pop the write pointer laps; read pointer and count stay
    always_ff @(posedge core_clk) begin
        if (srst || flush) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wp <= wp + AW'(1);
            end
            if (do_pop) begin
                rp <= rp + AW'(1);
            end
            if (do_push && !do_pop && !full) begin
                count <= count + (AW+1)'(1);
            end else if (do_pop && !do_push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end

endmodule : smf_fifo

// file: testbench/smf_props.sv
// port checker for the spi master block
`include "smf_cfg.svh"
module smf_props #(
    parameter int FIFO_DEPTH = 16,
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_clock_line,
    input wire logic serial_out_line,
    input wire logic serial_in_line,
    input wire logic [1:0] slave_select_n,
    input wire logic irq_n
);
    logic [7:0] ctrl_q;
    logic [7:0] div_q;
    logic [7:0] since;
    logic sclk_d;
    wire wr_ok = psel && penable && pready && pwrite;
    wire ctl_a = paddr == ADDR_W'(`SMF_IDX_CTRL * 4);
    wire div_a = paddr == ADDR_W'(`SMF_IDX_DIV * 4);
    wire mapped = (paddr >> 4) == (ADDR_W'(`SMF_IDX_DATA) >> 2) && paddr[1:0] == 2'h0;
    wire sclk_chg = serial_clock_line != sclk_d;
    wire [1:0] ss_exp = !ctrl_q[4] ? 2'b11 : (ctrl_q[5] ? 2'b01 : 2'b10);
    always_ff @(posedge core_clk) begin
        sclk_d <= serial_clock_line;
        if (srst) begin
            ctrl_q <= `SMF_CTRL_RESET;
            div_q <= `SMF_DIV_RESET;
            since <= 8'hff;
        end else begin
            if (wr_ok && ctl_a) ctrl_q <= pwdata[7:0];
            if (wr_ok && div_a) div_q <= pwdata[7:0];
            since <= sclk_chg ? 8'h00 : (since == 8'hff ? since : since + 8'h01);
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_ready_follows: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("wrong slave error");
    a_ctrl_read: assert property (pready && !pwrite && ctl_a |->
        prdata == {25'h0, ctrl_q[6:0]}) else $error("control readback");
    a_select_follow: assert property (wr_ok && ctl_a |->
        ##[1:3] slave_select_n == ss_exp) else $error("select line");
    a_sclk_idle: assert property ((&slave_select_n && $stable(ctrl_q)) [*3] |->
        serial_clock_line == ctrl_q[1]) else $error("clock idle level");
    a_half_period: assert property (sclk_chg |-> since >= div_q)
        else $error("clock too fast");
    a_out_steady: assert property (sclk_chg && !(&slave_select_n) &&
        serial_clock_line == !(ctrl_q[1] ^ ctrl_q[0]) |-> $stable(serial_out_line))
        else $error("data moved at sample edge");
    a_irq_masked: assert property (ctrl_q[6] [*2] |-> irq_n)
        else $error("masked interrupt");
    a_irq_quiet: assert property ((ctrl_q[3:2] == 2'b00) [*2] |-> irq_n)
        else $error("interrupt without enable");
endmodule : smf_props

bind smf_top smf_props #(.FIFO_DEPTH(FIFO_DEPTH), .ADDR_W(ADDR_W)) i_props (.core_clk,
    .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serial_clock_line, .serial_out_line, .serial_in_line, .slave_select_n, .irq_n);

// file: testbench/smf_slave.sv
// spi slave model: shift register that returns the previous byte
module smf_slave #(
    parameter logic [7:0] FIRST = 8'h3c
) (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic mosi,
    output logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh = FIRST;
    // capture on the sampling edge of the mode
    always @(sclk) begin
        if (!sel_n && sclk == !(cpol ^ cpha)) begin
            sh <= {sh[6:0], mosi};
        end
    end
    // released line shows the inverse bit
    assign miso = sel_n ? ~sh[7] : sh[7];
endmodule : smf_slave

// file: testbench/tb.sv
// self-checking bench for the spi master block
`include "smf_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_DAT = 12'(`SMF_IDX_DATA * 4);
    localparam logic [11:0] A_CTL = 12'(`SMF_IDX_CTRL * 4);
    localparam logic [11:0] A_STA = 12'(`SMF_IDX_STAT * 4);
    localparam logic [11:0] A_DIV = 12'(`SMF_IDX_DIV * 4);
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, acc;
    logic pready, pslverr, sclk, mosi, miso, irq_n, err;
    logic [1:0] ss_n;
    logic [1:0] mode = 2'b00;
    logic [31:0] seed = 32'hbc81;
    logic [7:0] shadow = 8'h3c;
    logic [7:0] b;
    logic [7:0] txq[16];
    logic [7:0] rxq[$];
    int failures = 0;
    int n_tests = 0;
    int n;
    always #12.5 core_clk = ~core_clk;
    smf_top i_dut (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .serial_clock_line(sclk), .serial_out_line(mosi),
        .serial_in_line(miso), .slave_select_n(ss_n), .irq_n);
    smf_slave #(.FIRST(8'h3c)) i_slave (.sclk, .sel_n(&ss_n), .cpol(mode[1]),
        .cpha(mode[0]), .mosi, .miso);
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic guard(input int k, input int lim);
        if (k > lim) begin
            failures++;
            tally_and_finish();
        end
    endtask : guard
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
            guard(k, 50);
        end while (pready !== 1'b1);
        acc = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(acc, e);
    endtask : rd
    task automatic poll(input logic [31:0] e);
        int k;
        k = 0;
        do begin
            apb(1'b0, A_STA, 8'h00);
            k++;
            guard(k, 2000);
        end while (acc !== e);
        chk(acc, e);
    endtask : poll
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        rd(A_CTL, 32'h00);
        rd(A_DIV, 32'h1f);
        rd(A_STA, 32'h90);
        rd(12'h2f0, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            b = 8'h04 | 8'(m) | (8'(m & 1) << 5);
            n = 2 + int'(xs() % 4);
            wr(A_DIV, 8'(n));
            rd(A_DIV, n);
            wr(A_CTL, b);
            wr(A_CTL, b | 8'h10);
            for (int k = 0; k < 4; k++) begin
                wr(A_DAT, 8'(xs()));
                rxq.push_back(shadow);
                shadow = pwdata[7:0];
            end
            n = 0;
            while (irq_n !== 1'b0) begin
                @(posedge core_clk);
                n++;
                guard(n, 5000);
            end
            poll(32'h84);
            wr(A_STA, 8'h04);
            repeat (2) @(posedge core_clk);
            chk({31'h0, irq_n}, 32'h1);
            repeat (4) rd(A_DAT, {24'h0, rxq.pop_front()});
            rd(A_STA, 32'h90);
            wr(A_CTL, b);
            $display("test mode %0d done", m);
        end
        mode = 2'b00;
        wr(A_CTL, 8'h08);
        for (int k = 0; k < 17; k++) begin
            b = 8'(xs());
            wr(A_DAT, b);
            txq[k % 16] = b;
        end
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq_n}, 32'h0);
        rd(A_STA, 32'h58);
        wr(A_CTL, 8'h48);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq_n}, 32'h1);
        wr(A_STA, 8'h08);
        rd(A_STA, 32'h50);
        wr(A_CTL, 8'h18);
        for (int k = 0; k < 16; k++) begin
            rxq.push_back(shadow);
            shadow = txq[k];
        end
        poll(32'ha4);
        repeat (15) rd(A_DAT, {24'h0, rxq.pop_front()});
        rd(A_STA, 32'h84);
        wr(A_CTL, 8'h08);
        rd(A_STA, 32'h94);
        wr(A_CTL, 8'h18);
        b = 8'(xs());
        wr(A_DAT, b);
        poll(32'h84);
        rd(A_DAT, {24'h0, shadow});
        $display("test overflow done");
        tally_and_finish();
    end
endmodule : tb
